// file: logic/dmsu_pkg.sv
package dmsu_pkg;
    // Opcode byte values
    localparam logic [7:0] OPC_BYTE_COPY = 8'h6a;
    localparam logic [7:0] OPC_LONG_COPY = 8'h5a;
    localparam logic [7:0] OPC_WORD_MEM_COPY = 8'h60;
    localparam logic [7:0] OPC_WORD_REG_COPY = 8'h20;
    localparam logic [7:0] OPC_CHAR_PAD_COPY = 8'h54;
    localparam logic [7:0] OPC_PC_SAVE = 8'h3a;
    localparam logic [7:0] OPC_WORD_WRITE = 8'hfa;
    localparam logic [7:0] OPC_BYTE_WRITE = 8'hf8;
    localparam logic [7:0] OPC_DWORD_LOAD = 8'h70;
    // Default blank fill byte
    localparam logic [7:0] PAD_CHAR_DEF = 8'h20;
    // Transfer steps and counts in bytes
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [15:0] CNT_DWORD = 16'h0004;
    // Buffer depth and full level
    localparam int BUF_DEPTH = 2;
    localparam logic [1:0] BUF_FULL = 2'h2;
    // Reset values
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [2:0] REG_NONE = 3'h0;

    // One decoded instruction with its extension words
    typedef struct packed {
        logic [7:0] opcode;
        logic ind1;
        logic [2:0] first_reg_sel;
        logic ind2;
        logic [2:0] second_reg_sel;
        logic [15:0] first_base_word;
        logic [15:0] second_base_word;
        logic [15:0] len_word;
        logic [15:0] pc;
    } dmsu_insn_t;

    // Main storage request
    typedef struct packed {
        logic req;
        logic we;
        logic wide;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dmsu_mem_t;

    // Sequencer states
    typedef enum logic [7:0] {
        S_IDLE = 8'h01,
        S_OP1 = 8'h02,
        S_IND1 = 8'h04,
        S_OP2 = 8'h08,
        S_IND2 = 8'h10,
        S_SETUP = 8'h20,
        S_RD = 8'h40,
        S_WR = 8'h80
    } dmsu_state_t;
endpackage : dmsu_pkg

// file: logic/dmsu_core.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Byte copy moves one memory byte
// - Address is base plus index, maybe indirect
// - Deref flag takes operand from memory via register
// - Long copy uses one 16-bit length
// - Long and char copy: indexing only
// - Long copy runs byte by byte unless length and addresses are even
// - Overlapping long copy stays correct
// - Zero length moves nothing
// - Even length and addresses move words
// - Word copy memory to memory
// - Word move register or memory operands
// - Char copy has two 8-bit lengths
// - Copy shorter length, pad with blanks
// - Empty source fills destination with blanks
// - Blanks fill rightmost destination bytes
// - Char copy words only when all even
// - Save program address to register or memory
// - Word store to first operand address
// - Byte store of register low byte
// - Register pair wraps seven to zero
module dmsu_core #(
    parameter logic [7:0] PAD_CHAR = dmsu_pkg::PAD_CHAR_DEF
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Instruction stream
    input wire logic ins_valid,
    input wire dmsu_pkg::dmsu_insn_t ins_data,
    output logic ins_ready,
    output logic op_done,
    // Main storage
    output dmsu_pkg::dmsu_mem_t mem_o,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    // General registers
    output logic [2:0] rf_rd_sel,
    input wire logic [15:0] rf_rd_data,
    output logic rf_we,
    output logic [2:0] rf_wr_sel,
    output logic [15:0] rf_wr_data
);
    import dmsu_pkg::*;

    // Index added only for a nonzero register selector
    function automatic logic [15:0] form_ea(logic [15:0] base, logic [2:0] sel,
                                            logic [15:0] rv);
        form_ea = base + ((sel != REG_NONE) ? rv : ZERO16);
    endfunction : form_ea

    // Next register of a pair, seven wraps to zero
    function automatic logic [2:0] next_reg(logic [2:0] sel);
        next_reg = sel + 3'h1;
    endfunction : next_reg

    // Opcodes this block executes
    function automatic logic is_known(logic [7:0] op);
        is_known = (op == OPC_BYTE_COPY) || (op == OPC_LONG_COPY) ||
                   (op == OPC_WORD_MEM_COPY) || (op == OPC_WORD_REG_COPY) ||
                   (op == OPC_CHAR_PAD_COPY) || (op == OPC_PC_SAVE) ||
                   (op == OPC_WORD_WRITE) || (op == OPC_BYTE_WRITE) ||
                   (op == OPC_DWORD_LOAD);
    endfunction : is_known

    // Reset release synchroniser
    logic [1:0] rs_q;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rs_q <= 2'h0;
        end else begin
            rs_q <= {rs_q[0], 1'b1};
        end
    end
    wire rst_sync_b = rs_q[1];

    // Two-entry instruction buffer; a busy sequencer backs up to ins_ready
    dmsu_insn_t buf_mem [BUF_DEPTH];
    logic wp_r, rp_r;
    logic [1:0] fill_r;
    dmsu_state_t st_r, st_nxt;
    wire buf_valid = (fill_r != 2'h0);
    wire push = ins_valid && ins_ready;
    wire pop = buf_valid && (st_r == S_IDLE);
    wire [7:0] hop = buf_mem[rp_r].opcode;
    assign ins_ready = (fill_r != BUF_FULL);

    // Buffer storage, no reset needed
    always_ff @(posedge core_clk) begin
        if (push) begin
            buf_mem[wp_r] <= ins_data;
        end
    end

    // Buffer pointers and fill level
    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            fill_r <= 2'h0;
        end else begin
            wp_r <= wp_r ^ push;
            rp_r <= rp_r ^ pop;
            fill_r <= fill_r + {1'b0, push} - {1'b0, pop};
        end
    end

    // Working state of the current instruction
    dmsu_insn_t cur_r;
    logic [15:0] sa_r, da_r, d_r, cnt_r, pad_r; // Source/dest address, data, counts
    logic wide_r, down_r; // Word steps, descending walk
    logic k1_r, k2_r; // Operand is a plain register
    logic src_reg_r, src_pc_r, dst_reg_r;
    logic [2:0] ssel_r, dsel_r;
    dmsu_mem_t mem_r;
    logic rf_we_r, done_r;
    logic [2:0] rf_sel_r;
    logic [15:0] rf_dat_r;

    // Opcode decode
    wire [7:0] opc = cur_r.opcode;
    wire is_lng = (opc == OPC_LONG_COPY);
    wire is_chr = (opc == OPC_CHAR_PAD_COPY);
    wire is_blk = is_lng || is_chr;
    wire is_rr = (opc == OPC_WORD_REG_COPY);
    wire is_pc = (opc == OPC_PC_SAVE);
    wire is_st = (opc == OPC_WORD_WRITE) || (opc == OPC_BYTE_WRITE);
    wire is_ld2 = (opc == OPC_DWORD_LOAD);
    wire is_byt = (opc == OPC_BYTE_COPY) || (opc == OPC_BYTE_WRITE);
    wire k2_kind = is_rr || is_pc || is_st || is_ld2;

    // Effective addresses from base words
    wire [15:0] ea1 = form_ea(cur_r.first_base_word, cur_r.first_reg_sel, rf_rd_data);
    wire [15:0] ea2 = form_ea(cur_r.second_base_word, cur_r.second_reg_sel, rf_rd_data);

    // Character copy lengths and split
    wire [7:0] src_length = cur_r.len_word[15:8];
    wire [7:0] dst_length = cur_r.len_word[7:0];
    wire [7:0] chr_min = (src_length < dst_length) ? src_length : dst_length;
    wire [7:0] chr_pad = (dst_length > src_length) ? dst_length - src_length : 8'h00;
    wire chr_even = !src_length[0] && !dst_length[0] && !sa_r[0] && !da_r[0];

    // Long copy width and direction
    wire lng_even = !cur_r.len_word[0] && !sa_r[0] && !da_r[0];
    wire lng_down = (da_r > sa_r) && (cur_r.len_word != ZERO16);
    wire [15:0] lng_back = cur_r.len_word - (lng_even ? STEP_WORD : STEP_BYTE);

    // Pointer stepping
    wire [15:0] step = wide_r ? STEP_WORD : STEP_BYTE;
    wire [15:0] sa_adv = down_r ? sa_r - step : sa_r + step;
    wire [15:0] da_adv = down_r ? da_r - step : da_r + step;

    // Storage access selection
    wire in_ind = (st_r == S_IND1) || (st_r == S_IND2);
    wire rd_mem = (st_r == S_RD) && (cnt_r != ZERO16) && !src_reg_r && !src_pc_r;
    wire wr_mem = (st_r == S_WR) && !dst_reg_r;
    wire launch = (in_ind || rd_mem || wr_mem) && !mem_r.req;
    wire ack_ok = mem_ack && mem_r.req;
    wire [15:0] go_addr = ((st_r == S_IND1) || rd_mem) ? sa_r : da_r;
    wire go_wide = in_ind || wide_r;

    // Next state
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            S_IDLE: begin
                if (buf_valid && is_known(hop)) begin
                    st_nxt = (hop == OPC_PC_SAVE) ? S_OP2 : S_OP1;
                end
            end
            S_OP1: begin
                // Block copies never go indirect
                st_nxt = (!is_rr && cur_r.ind1 && !is_blk) ? S_IND1 : S_OP2;
            end
            S_IND1: begin
                if (ack_ok) st_nxt = S_OP2;
            end
            S_OP2: begin
                st_nxt = (!k2_kind && cur_r.ind2 && !is_blk) ? S_IND2 : S_SETUP;
            end
            S_IND2: begin
                if (ack_ok) st_nxt = S_SETUP;
            end
            S_SETUP: begin
                st_nxt = S_RD;
            end
            S_RD: begin
                if (cnt_r != ZERO16) begin
                    st_nxt = (rd_mem && !ack_ok) ? S_RD : S_WR;
                end else if (pad_r != ZERO16) begin
                    st_nxt = S_WR;
                end else begin
                    st_nxt = S_IDLE;
                end
            end
            S_WR: begin
                if (dst_reg_r || ack_ok) st_nxt = S_RD;
            end
        endcase
    end

    // Register selection follows the phase
    assign rf_rd_sel = (st_r == S_OP1) ? cur_r.first_reg_sel :
                       (st_r == S_OP2) ? cur_r.second_reg_sel : ssel_r;

    // Sequencer datapath
    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            st_r <= S_IDLE;
            cur_r <= '0;
            {sa_r, da_r, d_r, cnt_r, pad_r} <= {5{ZERO16}};
            {wide_r, down_r, k1_r, k2_r} <= 4'h0;
            {src_reg_r, src_pc_r, dst_reg_r} <= 3'h0;
            ssel_r <= REG_NONE;
            dsel_r <= REG_NONE;
            mem_r <= '0;
            rf_we_r <= 1'b0;
            rf_sel_r <= REG_NONE;
            rf_dat_r <= ZERO16;
            done_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            rf_we_r <= 1'b0;
            done_r <= 1'b0;
            // Storage request held until acknowledged
            if (launch) begin
                mem_r <= '{req: 1'b1, we: wr_mem, wide: go_wide, addr: go_addr, wdata: d_r};
            end else if (ack_ok) begin
                mem_r.req <= 1'b0;
            end
            unique case (st_r)
                S_IDLE: begin
                    if (pop) cur_r <= buf_mem[rp_r];
                    k1_r <= 1'b0;
                end
                S_OP1: begin
                    k1_r <= is_rr && !cur_r.ind1;
                    sa_r <= is_rr ? rf_rd_data : ea1;
                end
                S_IND1: begin
                    if (ack_ok) sa_r <= mem_rdata;
                end
                S_OP2: begin
                    k2_r <= k2_kind && !cur_r.ind2;
                    da_r <= k2_kind ? rf_rd_data : ea2;
                end
                S_IND2: begin
                    if (ack_ok) da_r <= mem_rdata;
                end
                S_SETUP: begin
                    src_pc_r <= is_pc;
                    src_reg_r <= is_st ? k2_r : k1_r;
                    dst_reg_r <= !is_st && k2_r;
                    ssel_r <= is_st ? cur_r.second_reg_sel : cur_r.first_reg_sel;
                    dsel_r <= cur_r.second_reg_sel;
                    pad_r <= ZERO16;
                    down_r <= 1'b0;
                    // Stores write the first operand from the second
                    if (is_st) begin
                        sa_r <= da_r;
                        da_r <= sa_r;
                    end
                    if (is_lng) begin
                        cnt_r <= cur_r.len_word;
                        wide_r <= lng_even;
                        // Walk from the top end when the target lies above
                        down_r <= lng_down;
                        if (lng_down) begin
                            sa_r <= sa_r + lng_back;
                            da_r <= da_r + lng_back;
                        end
                    end else if (is_chr) begin
                        cnt_r <= {8'h00, chr_min};
                        pad_r <= {8'h00, chr_pad};
                        wide_r <= chr_even;
                    end else if (is_byt) begin
                        cnt_r <= STEP_BYTE;
                        wide_r <= 1'b0;
                    end else begin
                        cnt_r <= is_ld2 ? CNT_DWORD : STEP_WORD;
                        wide_r <= 1'b1;
                    end
                end
                S_RD: begin
                    if (cnt_r != ZERO16) begin
                        if (src_pc_r) begin
                            d_r <= cur_r.pc;
                        end else if (src_reg_r) begin
                            d_r <= rf_rd_data;
                        end else if (ack_ok) begin
                            d_r <= mem_rdata;
                        end
                    end else if (pad_r != ZERO16) begin
                        d_r <= {PAD_CHAR, PAD_CHAR};
                    end else begin
                        done_r <= 1'b1;
                    end
                end
                S_WR: begin
                    if (dst_reg_r || ack_ok) begin
                        rf_we_r <= dst_reg_r;
                        rf_sel_r <= dsel_r;
                        rf_dat_r <= d_r;
                        dsel_r <= next_reg(dsel_r);
                        da_r <= da_adv;
                        // Copy phase first, blank phase after it
                        if (cnt_r != ZERO16) begin
                            cnt_r <= cnt_r - step;
                            sa_r <= sa_adv;
                        end else begin
                            pad_r <= pad_r - step;
                        end
                    end
                end
            endcase
        end
    end

    // Outputs from flip-flops
    assign mem_o = mem_r;
    assign rf_we = rf_we_r;
    assign rf_wr_sel = rf_sel_r;
    assign rf_wr_data = rf_dat_r;
    assign op_done = done_r;

    // Checks on the sequencer
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync_b);

    property p_byte_narrow;
        (mem_r.req && mem_r.we && opc == OPC_BYTE_COPY) |-> !mem_r.wide;
    endproperty
    a_byte_narrow: assert property (p_byte_narrow) else $error("byte copy wrote a word");

    property p_no_ind;
        (st_r == S_OP1 && is_blk) |=> (st_r == S_OP2) ##1 (st_r == S_SETUP);
    endproperty
    a_no_ind: assert property (p_no_ind) else $error("block copy went indirect");

    property p_zero_len;
        (st_r == S_SETUP && is_lng && cur_r.len_word == ZERO16)
            |=> (st_r == S_RD && cnt_r == ZERO16) ##1 (st_r == S_IDLE && op_done);
    endproperty
    a_zero_len: assert property (p_zero_len) else $error("zero length moved data");

    property p_long_wide;
        (st_r == S_SETUP && is_lng) |=> (wide_r == $past(lng_even));
    endproperty
    a_long_wide: assert property (p_long_wide) else $error("long copy width wrong");

    property p_overlap;
        (st_r == S_SETUP && is_lng && lng_down)
            |=> down_r && (da_r == $past(da_r) + $past(lng_back));
    endproperty
    a_overlap: assert property (p_overlap) else $error("overlap walk wrong");

    property p_chr_len;
        (st_r == S_SETUP && is_chr)
            |=> (cnt_r == {8'h00, $past(chr_min)}) && (pad_r == {8'h00, $past(chr_pad)});
    endproperty
    a_chr_len: assert property (p_chr_len) else $error("char copy split wrong");

    property p_chr_blank;
        (st_r == S_SETUP && is_chr && src_length == 8'h00 && dst_length != 8'h00)
            |=> (cnt_r == ZERO16) ##1 (d_r[7:0] == PAD_CHAR);
    endproperty
    a_chr_blank: assert property (p_chr_blank) else $error("empty source not blanked");

    property p_chr_word;
        (st_r == S_SETUP && is_chr && !chr_even) |=> !wide_r;
    endproperty
    a_chr_word: assert property (p_chr_word) else $error("odd char copy used words");

    property p_pc_save;
        (rf_we_r && opc == OPC_PC_SAVE) |-> (rf_dat_r == cur_r.pc);
    endproperty
    a_pc_save: assert property (p_pc_save) else $error("saved address wrong");

    // Pair starts at the named register and steps to the next one
    property p_pair_wrap;
        (rf_we_r && is_ld2)
            |-> (dsel_r == rf_sel_r + 3'h1)
                && ((cnt_r == ZERO16) || (rf_sel_r == cur_r.second_reg_sel));
    endproperty
    a_pair_wrap: assert property (p_pair_wrap) else $error("pair register wrong");

    // Main scenarios reached
    c_long_down: cover property (st_r == S_SETUP && lng_down);
    c_chr_pad: cover property (st_r == S_WR && cnt_r == ZERO16 && pad_r != ZERO16);
    c_pair_wrap: cover property (rf_we_r && is_ld2 && rf_sel_r == REG_NONE);
    c_buf_full: cover property (!ins_ready && st_r == S_RD);
endmodule : dmsu_core

// file: bench/dmsu_store_model.sv
`timescale 1ns/1ps
// Shared main storage and general registers facing the block
module dmsu_store_model (
    // Clock
    input wire logic core_clk,
    // Storage side
    input wire dmsu_pkg::dmsu_mem_t mem_o,
    output logic mem_ack,
    output logic [15:0] mem_rdata,
    input wire logic [3:0] lat,
    // Register side
    input wire logic [2:0] rf_rd_sel,
    output logic [15:0] rf_rd_data,
    input wire logic rf_we,
    input wire logic [2:0] rf_wr_sel,
    input wire logic [15:0] rf_wr_data
);
    import dmsu_pkg::*;
    logic [7:0] mem [0:65535]; // Bytes, MS byte of a word first
    logic [15:0] regs [0:7]; // General registers
    logic [3:0] wait_r = 4'h0; // Cycles waited on this access
    wire [15:0] a = mem_o.addr; // Current address
    initial begin
        mem_ack = 1'b0;
        mem_rdata = 16'h0000;
    end
    // Combinational register read
    assign rf_rd_data = regs[rf_rd_sel];
    // Register write on pulse
    always @(posedge core_clk) begin
        if (rf_we === 1'b1) begin
            regs[rf_wr_sel] <= rf_wr_data;
        end
    end
    // Answer after lat idle cycles; data churns off-answer so stale data never looks valid
    always @(posedge core_clk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_o.req === 1'b1 && !mem_ack) begin
            if (wait_r >= lat) begin
                wait_r <= 4'h0;
                mem_ack <= 1'b1;
                if (!mem_o.we) begin
                    mem_rdata <= mem_o.wide ? {mem[a], mem[a + 16'h1]} : {8'h00, mem[a]};
                end else if (mem_o.wide) begin
                    {mem[a], mem[a + 16'h1]} <= mem_o.wdata;
                end else begin
                    mem[a] <= mem_o.wdata[7:0];
                end
            end else begin
                wait_r <= wait_r + 4'h1;
            end
        end
    end
endmodule : dmsu_store_model

// file: bench/dmsu_core_test.sv
`timescale 1ns/1ps
// Self-checking bench for the data move and store block
module dmsu_core_test;
    import dmsu_pkg::*;
    localparam logic [7:0] PAD = 8'h2e; // Non-default blank, shows it is configurable
    logic core_clk = 1'b0;
    logic rst_b, ins_valid, ins_ready, op_done, mem_ack, rf_we;
    dmsu_insn_t ins_data;
    dmsu_mem_t mem_o;
    logic [15:0] mem_rdata, rf_rd_data, rf_wr_data;
    logic [2:0] rf_rd_sel, rf_wr_sel;
    logic [3:0] lat; // Storage answer delay
    int fail_count = 0, num_checks = 0, cycles = 0, done_cnt = 0, exp_done = 0, wides = 0;
    logic saw_full = 1'b0; // Buffer was seen refusing
    dmsu_core #(.PAD_CHAR(PAD)) dmsu_core_inst (.core_clk(core_clk), .rst_b(rst_b),
        .ins_valid(ins_valid), .ins_data(ins_data), .ins_ready(ins_ready), .op_done(op_done),
        .mem_o(mem_o), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .rf_rd_sel(rf_rd_sel),
        .rf_rd_data(rf_rd_data), .rf_we(rf_we), .rf_wr_sel(rf_wr_sel), .rf_wr_data(rf_wr_data));
    dmsu_store_model dmsu_store_model_inst (.core_clk(core_clk), .mem_o(mem_o),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .lat(lat), .rf_rd_sel(rf_rd_sel),
        .rf_rd_data(rf_rd_data), .rf_we(rf_we), .rf_wr_sel(rf_wr_sel), .rf_wr_data(rf_wr_data));
    // 100 ns clock
    always #50 core_clk = ~core_clk;
    // Event counters and hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (op_done === 1'b1) done_cnt++;
        if (mem_o.req === 1'b1 && mem_ack && mem_o.we && mem_o.wide) wides++;
        if (ins_valid && ins_ready === 1'b0) saw_full = 1'b1;
        if (cycles == 30000) begin
            fail_count++;
            $display("BAD %0t hang", $time);
            summarize();
        end
    end
    // Verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    // Compare seen against expected
    task automatic check(logic [15:0] seen, logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask : check
    // Build an instruction, f = {deref, selector}
    function automatic dmsu_insn_t mk(logic [7:0] op, logic [3:0] f1, logic [3:0] f2,
                                      logic [15:0] b1, logic [15:0] b2, logic [15:0] len);
        return '{op, f1[3], f1[2:0], f2[3], f2[2:0], b1, b2, len, 16'h1357};
    endfunction : mk
    // Storage word access, MS byte first
    function automatic logic [15:0] w(logic [15:0] a);
        return {dmsu_store_model_inst.mem[a], dmsu_store_model_inst.mem[a + 16'h1]};
    endfunction : w
    task automatic sw(logic [15:0] a, logic [15:0] v);
        {dmsu_store_model_inst.mem[a], dmsu_store_model_inst.mem[a + 16'h1]} = v;
    endtask : sw
    // Offer one instruction and hold it until taken
    task automatic send(dmsu_insn_t i);
        ins_data <= i;
        ins_valid <= 1'b1;
        do @(negedge core_clk); while (ins_ready !== 1'b1);
        @(posedge core_clk);
    endtask : send
    // Wait for n completions under a bound
    task automatic finish_ops(int n);
        ins_valid <= 1'b0;
        exp_done += n;
        repeat (3000) begin
            @(negedge core_clk);
            if (done_cnt >= exp_done) break;
        end
        check(16'(done_cnt), 16'(exp_done));
        @(posedge core_clk);
    endtask : finish_ops
    task automatic do_op(dmsu_insn_t i);
        send(i);
        finish_ops(1);
    endtask : do_op
    // Indexed source, indirect destination; then indexed indirect word copy, slow storage
    task automatic t_mem_copy();
        dmsu_store_model_inst.regs[1] = 16'h0010;
        dmsu_store_model_inst.mem[16'h0110] = 8'ha5;
        sw(16'h0200, 16'h0300);
        do_op(mk(OPC_BYTE_COPY, 4'h1, 4'h8, 16'h0100, 16'h0200, 16'h0));
        check({8'h00, dmsu_store_model_inst.mem[16'h0300]}, 16'h00a5);
        lat = 4'h3;
        dmsu_store_model_inst.regs[2] = 16'h0004;
        sw(16'h0400, 16'h0410);
        sw(16'h0410, 16'h1234);
        do_op(mk(OPC_WORD_MEM_COPY, 4'h9, 4'h2, 16'h03f0, 16'h0402, 16'h0));
        check(w(16'h0406), 16'h1234);
        lat = 4'h0;
        $display("mem copy done");
    endtask : t_mem_copy
    // Register and deref operands of the word move
    task automatic t_reg_move();
        dmsu_store_model_inst.regs[3] = 16'hbeef;
        dmsu_store_model_inst.regs[5] = 16'h0500;
        sw(16'h0500, 16'hcafe);
        do_op(mk(OPC_WORD_REG_COPY, 4'h3, 4'h4, 16'h0, 16'h0, 16'h0));
        check(dmsu_store_model_inst.regs[4], 16'hbeef);
        do_op(mk(OPC_WORD_REG_COPY, 4'hd, 4'h6, 16'h0, 16'h0, 16'h0));
        check(dmsu_store_model_inst.regs[6], 16'hcafe);
        do_op(mk(OPC_WORD_REG_COPY, 4'h3, 4'hd, 16'h0, 16'h0, 16'h0));
        check(w(16'h0500), 16'hbeef);
        $display("reg move done");
    endtask : t_reg_move
    // Zero length, overlapping bytes, word mode with deref flag ignored
    task automatic t_long_copy();
        int n;
        dmsu_store_model_inst.mem[16'h0700] = 8'h11;
        do_op(mk(OPC_LONG_COPY, 4'h0, 4'h0, 16'h0600, 16'h0700, 16'h0));
        check({8'h00, dmsu_store_model_inst.mem[16'h0700]}, 16'h0011);
        for (int k = 0; k < 8; k++) dmsu_store_model_inst.mem[16'h0800 + k] = 8'(k + 1);
        do_op(mk(OPC_LONG_COPY, 4'h0, 4'h0, 16'h0800, 16'h0801, 16'h5));
        for (int k = 0; k < 6; k++) begin
            check({8'h00, dmsu_store_model_inst.mem[16'h0801 + k]}, 16'(k < 5 ? k + 1 : 7));
        end
        sw(16'h0900, 16'h0102);
        sw(16'h0902, 16'h0304);
        n = wides;
        do_op(mk(OPC_LONG_COPY, 4'h9, 4'h0, 16'h08f0, 16'h0a00, 16'h4));
        check(w(16'h0a00), 16'h0102);
        check(w(16'h0a02), 16'h0304);
        check(16'(wides - n), 16'h2);
        $display("long copy done");
    endtask : t_long_copy
    // Character copy: copied bytes, then blanks, then untouched byte
    task automatic cc(int s, int d, logic [15:0] dst, int nw);
        int n;
        for (int k = 0; k < 9; k++) dmsu_store_model_inst.mem[dst + k] = 8'h00;
        n = wides;
        do_op(mk(OPC_CHAR_PAD_COPY, 4'h0, 4'h0, 16'h0b00, dst, {8'(s), 8'(d)}));
        for (int k = 0; k <= d; k++) begin
            check({8'h00, dmsu_store_model_inst.mem[dst + k]},
                  {8'h00, (k < s && k < d) ? 8'(8'h41 + k) : (k < d ? PAD : 8'h00)});
        end
        check(16'(wides - n), 16'(nw));
    endtask : cc
    task automatic t_char_copy();
        for (int k = 0; k < 8; k++) dmsu_store_model_inst.mem[16'h0b00 + k] = 8'(8'h41 + k);
        cc(3, 8, 16'h0c00, 0);
        cc(0, 2, 16'h0d00, 1);
        cc(4, 2, 16'h0e00, 1);
        cc(2, 4, 16'h0f20, 2);
        $display("char copy done");
    endtask : t_char_copy
    // Program address save, word and byte stores, two-word load wrapping
    task automatic t_store();
        do_op(mk(OPC_PC_SAVE, 4'h0, 4'h7, 16'h0, 16'h0, 16'h0));
        check(dmsu_store_model_inst.regs[7], 16'h1357);
        do_op(mk(OPC_PC_SAVE, 4'h0, 4'hd, 16'h0, 16'h0, 16'h0));
        check(w(16'h0500), 16'h1357);
        do_op(mk(OPC_WORD_WRITE, 4'h0, 4'h3, 16'h0f00, 16'h0, 16'h0));
        check(w(16'h0f00), 16'hbeef);
        sw(16'h0f10, 16'h0000);
        do_op(mk(OPC_BYTE_WRITE, 4'h0, 4'h3, 16'h0f10, 16'h0, 16'h0));
        check(w(16'h0f10), 16'hef00);
        sw(16'h1000, 16'h1111);
        sw(16'h1002, 16'h2222);
        do_op(mk(OPC_DWORD_LOAD, 4'h0, 4'h7, 16'h1000, 16'h0, 16'h0));
        check(dmsu_store_model_inst.regs[7], 16'h1111);
        check(dmsu_store_model_inst.regs[0], 16'h2222);
        $display("store done");
    endtask : t_store
    // Back-to-back copies behind slow storage fill the buffer; unknown code is dropped
    task automatic t_stream();
        lat = 4'h4;
        sw(16'h1100, 16'h5a5a);
        for (int k = 0; k < 3; k++) begin
            send(mk(k == 1 ? 8'h00 : OPC_WORD_MEM_COPY, 4'h0, 4'h0, 16'h1100, 16'(16'h1200 + 2 * k), 16'h0));
        end
        send(mk(OPC_WORD_MEM_COPY, 4'h0, 4'h0, 16'h1100, 16'h1206, 16'h0));
        finish_ops(3);
        repeat (30) @(posedge core_clk);
        check(16'(done_cnt), 16'(exp_done));
        check({15'h0, saw_full}, 16'h1);
        check(w(16'h1200), 16'h5a5a);
        check(w(16'h1206), 16'h5a5a);
        lat = 4'h0;
        $display("stream done");
    endtask : t_stream
    // Main sequence
    initial begin
        rst_b = 1'b0;
        ins_valid = 1'b0;
        ins_data = '0;
        lat = 4'h0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge core_clk);
        check({15'h0, mem_o.req}, 16'h0);
        t_mem_copy();
        t_reg_move();
        t_long_copy();
        t_char_copy();
        t_store();
        t_stream();
        summarize();
    end
endmodule : dmsu_core_test
